// >>> hdl/seq_pkg.sv
package seq_pkg;
  // main clock rate and tick timing
  localparam int unsigned clock_mhz = 250;
  localparam int unsigned tick_us = 32;
  localparam int unsigned tick_cycles = tick_us * clock_mhz;
  localparam logic [12:0] tick_last = 13'(tick_cycles - 1);
  // waits, each in its own unit, then converted to whole ticks rounding up
  localparam int unsigned plane_wait_ticks = 1;
  localparam int unsigned halt_hold_ms = 16;
  localparam int unsigned status_wait_ms = 1;
  localparam int unsigned pgood_wait_ticks = 1;
  localparam int unsigned tick_after_status = 1;
  localparam int unsigned halt_freeze_ticks = 2;
  localparam int unsigned cpu_release_ticks = 1;
  localparam logic [9:0] halt_hold_ticks = 10'((halt_hold_ms * 1000 + tick_us - 1) / tick_us);
  localparam logic [9:0] status_ticks = 10'((status_wait_ms * 1000 + tick_us - 1) / tick_us);
  localparam logic [9:0] tick_cnt_reset = 10'h000;
  typedef enum logic [3:0] {
    st_on,
    st_req_halt,
    st_wait_grant,
    st_sleep,
    st_status,
    st_halt,
    st_planes_off,
    st_suspended,
    st_resume_wait,
    st_core_wait,
    st_halt_release,
    st_status_wait,
    st_pci_release,
    st_cpu_release
  } seq_state_t;
endpackage

// >>> hdl/tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
  logic tick;
  modport source (output tick);
  modport sink (input tick);
endinterface
`default_nettype wire

// >>> hdl/tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
  parameter logic [12:0] tick_last = seq_pkg::tick_last
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  tick_if.source t
);
  logic [12:0] cnt_r;
  logic [12:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;
  // one pulse each roughly 32 us of the main clock
  always_comb begin
    tick_nxt = (cnt_r == tick_last);
    cnt_nxt = tick_nxt ? 13'h0000 : cnt_r + 13'h0001;
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_r <= 13'h0000;
      tick_r <= 1'b0;
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign t.tick = tick_r & clk_en;
endmodule
`default_nettype wire

// >>> hdl/disk_suspend_resume_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module disk_suspend_resume_sequencer #(
  // tick may be shortened for simulation; every wait is counted in ticks
  parameter logic [12:0] tick_last = seq_pkg::tick_last
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic suspend_request,
  input wire logic resume_event,
  input wire logic core_power_ok,
  input wire logic power_good,
  input wire logic stop_grant_done,
  input wire logic clock_control_en,
  output logic power_plane_suspend_n,
  output logic pci_clock_halt_n,
  output logic pci_clock_halt_oe,
  output logic processor_clock_halt_n,
  output logic processor_clock_halt_oe,
  output logic pci_reset_n,
  output logic processor_reset,
  output logic processor_sleep_n,
  output logic processor_clock_halt_request_n,
  output logic suspend_status_n,
  output logic suspend_tick_out,
  output logic halt_may_change
);
  tick_if tk ();
  tick_gen #(
    .tick_last(tick_last)
  ) u_tick (
    .clock(clock),
    .rstn(rstn),
    .clk_en(clk_en),
    .t(tk)
  );

  // pin inputs except clock_control_en cross two flops before any logic looks at them
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end else if (clk_en) begin
      sync1_r <= {suspend_request, resume_event, core_power_ok, power_good, stop_grant_done};
      sync2_r <= sync1_r;
    end
  end
  logic req_s;
  logic resume_s;
  logic core_s;
  logic pgood_s;
  logic grant_s;
  assign {req_s, resume_s, core_s, pgood_s, grant_s} = sync2_r;

  logic tick;
  assign tick = tk.tick;

  seq_pkg::seq_state_t state_r;
  seq_pkg::seq_state_t state_nxt;
  logic [9:0] cnt_r;
  logic [9:0] cnt_nxt;
  // 16 ms timer runs beside the main counter from plane release
  logic [9:0] plane_cnt_r;
  logic [9:0] plane_cnt_nxt;
  logic [9:0] pg_cnt_r;
  logic [9:0] pg_cnt_nxt;
  logic plane_n_r, plane_n_nxt;
  logic halt_n_r, halt_n_nxt;
  logic halt_oe_r, halt_oe_nxt;
  logic prst_n_r, prst_n_nxt;
  logic crst_r, crst_nxt;
  logic sleep_n_r, sleep_n_nxt;
  logic hreq_n_r, hreq_n_nxt;
  logic stat_n_r, stat_n_nxt;
  logic suspend_tick_out_en_r, suspend_tick_out_en_nxt;
  logic suspend_tick_out_r, suspend_tick_out_nxt;
  logic may_chg_r, may_chg_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    plane_cnt_nxt = plane_cnt_r;
    pg_cnt_nxt = pg_cnt_r;
    plane_n_nxt = plane_n_r;
    halt_n_nxt = halt_n_r;
    halt_oe_nxt = halt_oe_r;
    prst_n_nxt = prst_n_r;
    crst_nxt = crst_r;
    sleep_n_nxt = sleep_n_r;
    hreq_n_nxt = hreq_n_r;
    stat_n_nxt = stat_n_r;
    suspend_tick_out_en_nxt = suspend_tick_out_en_r;
    suspend_tick_out_nxt = suspend_tick_out_r;
    may_chg_nxt = may_chg_r;
    // suspend clock toggles per tick once enabled, low otherwise
    if (tick) begin
      suspend_tick_out_nxt = suspend_tick_out_en_r ? ~suspend_tick_out_r : 1'b0;
      if (plane_cnt_r != 10'h3ff) begin
        plane_cnt_nxt = plane_cnt_r + 10'h001;
      end
      if (pgood_s && pg_cnt_r != 10'h3ff) begin
        pg_cnt_nxt = pg_cnt_r + 10'h001;
      end
    end
    if (!pgood_s) begin
      pg_cnt_nxt = seq_pkg::tick_cnt_reset;
    end
    // core power up: outputs go to their safe levels without waiting
    if (core_s && (state_r == seq_pkg::st_resume_wait || state_r == seq_pkg::st_suspended)) begin
      halt_oe_nxt = 1'b0;
      prst_n_nxt = 1'b0;
      crst_nxt = 1'b1;
      sleep_n_nxt = 1'b1;
      hreq_n_nxt = 1'b1;
    end
    case (state_r)
      seq_pkg::st_on: begin
        if (req_s && tick) begin
          halt_n_nxt = 1'b1;
          halt_oe_nxt = 1'b1;
          may_chg_nxt = 1'b0;
          state_nxt = seq_pkg::st_req_halt;
        end
      end
      seq_pkg::st_req_halt: begin
        if (tick) begin
          hreq_n_nxt = 1'b0;
          state_nxt = seq_pkg::st_wait_grant;
        end
      end
      seq_pkg::st_wait_grant: begin
        if (tick && grant_s) begin
          sleep_n_nxt = 1'b0;
          state_nxt = seq_pkg::st_sleep;
        end
      end
      seq_pkg::st_sleep: begin
        if (tick) begin
          stat_n_nxt = 1'b0;
          suspend_tick_out_en_nxt = 1'b0;
          state_nxt = seq_pkg::st_status;
        end
      end
      seq_pkg::st_status: begin
        if (tick) begin
          halt_n_nxt = ~clock_control_en;
          state_nxt = seq_pkg::st_halt;
        end
      end
      seq_pkg::st_halt: begin
        if (tick) begin
          plane_n_nxt = 1'b0;
          state_nxt = seq_pkg::st_planes_off;
        end
      end
      seq_pkg::st_planes_off: begin
        // outputs stay as they are while power good holds
        if (tick && !pgood_s) begin
          halt_oe_nxt = 1'b0;
          prst_n_nxt = 1'b0;
          crst_nxt = 1'b1;
          sleep_n_nxt = 1'b1;
          hreq_n_nxt = 1'b1;
          state_nxt = seq_pkg::st_suspended;
        end
      end
      seq_pkg::st_suspended: begin
        if (resume_s) begin
          cnt_nxt = seq_pkg::tick_cnt_reset;
          state_nxt = seq_pkg::st_resume_wait;
        end
      end
      seq_pkg::st_resume_wait: begin
        // a tick is counted only after resume was seen, so one full tick passes
        if (tick) begin
          cnt_nxt = cnt_r + 10'h001;
          if (cnt_r >= 10'(seq_pkg::plane_wait_ticks)) begin
            plane_n_nxt = 1'b1;
            plane_cnt_nxt = seq_pkg::tick_cnt_reset;
            state_nxt = seq_pkg::st_core_wait;
          end
        end
      end
      seq_pkg::st_core_wait: begin
        if (core_s) begin
          halt_oe_nxt = 1'b0;
          prst_n_nxt = 1'b0;
          crst_nxt = 1'b1;
          sleep_n_nxt = 1'b1;
          hreq_n_nxt = 1'b1;
          if (pgood_s) begin
            halt_n_nxt = ~clock_control_en;
            halt_oe_nxt = 1'b1;
            state_nxt = seq_pkg::st_halt_release;
          end
        end
      end
      seq_pkg::st_halt_release: begin
        // counts are whole ticks past the cause, hence the +1 margin
        if (tick && plane_cnt_r > seq_pkg::halt_hold_ticks
            && pg_cnt_r > 10'(seq_pkg::pgood_wait_ticks)) begin
          halt_n_nxt = 1'b1;
          cnt_nxt = seq_pkg::tick_cnt_reset;
          state_nxt = seq_pkg::st_status_wait;
        end
      end
      seq_pkg::st_status_wait: begin
        if (tick) begin
          cnt_nxt = cnt_r + 10'h001;
          if (cnt_r > seq_pkg::status_ticks) begin
            stat_n_nxt = 1'b1;
            cnt_nxt = seq_pkg::tick_cnt_reset;
            state_nxt = seq_pkg::st_pci_release;
          end
        end
      end
      seq_pkg::st_pci_release: begin
        if (tick) begin
          // pci reset leaves on the first tick after status release
          prst_n_nxt = 1'b1;
          cnt_nxt = seq_pkg::tick_cnt_reset;
          state_nxt = seq_pkg::st_cpu_release;
        end
      end
      seq_pkg::st_cpu_release: begin
        if (tick) begin
          cnt_nxt = cnt_r + 10'h001;
          if (cnt_r == 10'(seq_pkg::tick_after_status - 1)) begin
            suspend_tick_out_en_nxt = 1'b1;
          end
          if (cnt_r == 10'(seq_pkg::cpu_release_ticks)) begin
            crst_nxt = 1'b0;
          end
          if (cnt_r == 10'(seq_pkg::halt_freeze_ticks)) begin
            may_chg_nxt = 1'b1;
            state_nxt = seq_pkg::st_on;
          end
        end
      end
      default: state_nxt = seq_pkg::st_on;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      // reset lands in the powered, running state
      state_r <= seq_pkg::st_on;
      cnt_r <= seq_pkg::tick_cnt_reset;
      plane_cnt_r <= seq_pkg::tick_cnt_reset;
      pg_cnt_r <= seq_pkg::tick_cnt_reset;
      plane_n_r <= 1'b1;
      halt_n_r <= 1'b1;
      halt_oe_r <= 1'b1;
      prst_n_r <= 1'b1;
      crst_r <= 1'b0;
      sleep_n_r <= 1'b1;
      hreq_n_r <= 1'b1;
      stat_n_r <= 1'b1;
      suspend_tick_out_en_r <= 1'b1;
      suspend_tick_out_r <= 1'b0;
      may_chg_r <= 1'b1;
    end else if (clk_en) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      plane_cnt_r <= plane_cnt_nxt;
      pg_cnt_r <= pg_cnt_nxt;
      plane_n_r <= plane_n_nxt;
      halt_n_r <= halt_n_nxt;
      halt_oe_r <= halt_oe_nxt;
      prst_n_r <= prst_n_nxt;
      crst_r <= crst_nxt;
      sleep_n_r <= sleep_n_nxt;
      hreq_n_r <= hreq_n_nxt;
      stat_n_r <= stat_n_nxt;
      suspend_tick_out_en_r <= suspend_tick_out_en_nxt;
      suspend_tick_out_r <= suspend_tick_out_nxt;
      may_chg_r <= may_chg_nxt;
    end
  end

  assign power_plane_suspend_n = plane_n_r;
  assign pci_clock_halt_n = halt_n_r;
  assign pci_clock_halt_oe = halt_oe_r;
  assign processor_clock_halt_n = halt_n_r;
  assign processor_clock_halt_oe = halt_oe_r;
  assign pci_reset_n = prst_n_r;
  assign processor_reset = crst_r;
  assign processor_sleep_n = sleep_n_r;
  assign processor_clock_halt_request_n = hreq_n_r;
  assign suspend_status_n = stat_n_r;
  assign suspend_tick_out = suspend_tick_out_r;
  assign halt_may_change = may_chg_r;
endmodule
`default_nettype wire

// >>> dv/seq_chk.sv
`timescale 1ns/1ps
`default_nettype none
module seq_chk #(
  parameter int unsigned tick_cycles = seq_pkg::tick_cycles
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic resume_event,
  input wire logic power_good,
  input wire logic stop_grant_done,
  input wire logic clock_control_en,
  input wire logic power_plane_suspend_n,
  input wire logic pci_clock_halt_n,
  input wire logic pci_clock_halt_oe,
  input wire logic processor_clock_halt_n,
  input wire logic processor_clock_halt_oe,
  input wire logic pci_reset_n,
  input wire logic processor_reset,
  input wire logic processor_sleep_n,
  input wire logic processor_clock_halt_request_n,
  input wire logic suspend_status_n,
  input wire logic suspend_tick_out,
  input wire logic halt_may_change
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  logic [22:0] c_r [6];
  logic [22:0] c_nxt [6];
  logic [5:0] lv;
  assign lv = {power_good, suspend_status_n, pci_reset_n, pci_clock_halt_n & pci_clock_halt_oe,
    power_plane_suspend_n, resume_event};
  // run length of each level, saturating so a long on state cannot wrap
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      c_nxt[i] = lv[i] ? c_r[i] + 23'(c_r[i] != '1) : 23'h0;
    end
  end
  always_ff @(posedge clock) begin
    for (int i = 0; i < 6; i++) begin
      c_r[i] <= rstn ? c_nxt[i] : 23'h0;
    end
  end
  // one millisecond in cycles of the tick-scaled time base
  localparam int unsigned ms_cycles = 1000 * tick_cycles / seq_pkg::tick_us;
  plane_wait_a: assert property ($rose(power_plane_suspend_n) |-> c_r[0] >= tick_cycles)
    else $error("plane suspend released too early");
  safe_levels_a: assert property ($rose(power_good) |->
    !pci_reset_n && processor_reset && processor_sleep_n && processor_clock_halt_request_n && !pci_clock_halt_oe)
    else $error("outputs not at safe levels when power good rose");
  halt_hold_a: assert property ($rose(pci_clock_halt_n & pci_clock_halt_oe) |-> c_r[1] >= 16 * ms_cycles)
    else $error("clock halt released before 16 ms");
  halt_pgood_a: assert property ($rose(pci_clock_halt_n & pci_clock_halt_oe) |-> c_r[5] >= tick_cycles)
    else $error("clock halt released within a tick of power good");
  status_wait_a: assert property ($rose(suspend_status_n) |-> c_r[2] >= ms_cycles)
    else $error("status released before 1 ms");
  pci_release_a: assert property (c_r[4] == tick_cycles + 2 |-> pci_reset_n)
    else $error("pci reset still active a tick after status");
  may_change_a: assert property ($rose(halt_may_change) |-> c_r[4] >= 2 * tick_cycles)
    else $error("clock halt freed too soon");
  cpu_release_a: assert property ($fell(processor_reset) |-> c_r[3] >= tick_cycles)
    else $error("processor reset released too soon");
  tick_out_a: assert property ($rose(suspend_tick_out) |-> c_r[4] >= tick_cycles)
    else $error("suspend tick output started too soon after status release");
  halt_pair_a: assert property (processor_clock_halt_n == pci_clock_halt_n
    && processor_clock_halt_oe == pci_clock_halt_oe)
    else $error("processor and pci clock halt outputs differ");
  halt_gate_a: assert property ($rose(pci_clock_halt_oe & !pci_clock_halt_n) |-> $past(clock_control_en))
    else $error("clock halt driven without clock control");
  sleep_grant_a: assert property ($fell(processor_sleep_n) |-> $past(stop_grant_done, 3))
    else $error("sleep asserted before stop grant");
  cover property ($fell(processor_sleep_n));
  cover property ($rose(pci_clock_halt_n & pci_clock_halt_oe));
  cover property ($fell(processor_reset));
endmodule
`default_nettype wire

// >>> dv/seq_partner.sv
`timescale 1ns/1ps
`default_nettype none
module seq_partner #(
  parameter int pgood_delay = 250100,
  parameter int grant_delay = 20000
) (
  input wire logic clock,
  input wire logic slow,
  input wire logic power_plane_suspend_n,
  input wire logic processor_clock_halt_request_n,
  input wire logic pci_clock_halt_n,
  input wire logic pci_clock_halt_oe,
  output logic core_power_ok,
  output logic power_good,
  output logic stop_grant_done,
  output logic clocks_running
);
  initial begin
    core_power_ok = 1'b1;
    power_good = 1'b1;
    stop_grant_done = 1'b0;
    clocks_running = 1'b1;
  end
  // slow grant spans several ticks so the wait is really exercised
  always @(negedge processor_clock_halt_request_n) begin
    repeat (slow ? grant_delay : 5) @(negedge clock);
    stop_grant_done = !processor_clock_halt_request_n;
  end
  always @(posedge processor_clock_halt_request_n) stop_grant_done = 1'b0;
  always @(negedge power_plane_suspend_n) begin
    @(negedge clock) power_good = 1'b0;
    @(negedge clock) core_power_ok = 1'b0;
  end
  always @(posedge power_plane_suspend_n) begin
    repeat (10) @(negedge clock);
    core_power_ok = 1'b1;
    repeat (pgood_delay) @(negedge clock);
    power_good = 1'b1;
  end
  always @(pci_clock_halt_n or pci_clock_halt_oe) begin
    clocks_running <= #8 !(pci_clock_halt_oe && !pci_clock_halt_n);
  end
endmodule
`default_nettype wire

// >>> dv/disk_suspend_resume_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module disk_suspend_resume_sequencer_tb;
  logic clock, rstn, clk_en, suspend_request, resume_event, clock_control_en, slow, mon_on;
  wire logic core_power_ok, power_good, stop_grant_done, clocks_running, power_plane_suspend_n;
  wire logic pci_clock_halt_n, pci_clock_halt_oe, processor_clock_halt_n, processor_clock_halt_oe;
  wire logic pci_reset_n, processor_reset, processor_sleep_n, processor_clock_halt_request_n;
  wire logic suspend_status_n, suspend_tick_out, halt_may_change;
  int mismatches = 0;
  int n_tests = 0;
  int seed = 78;
  logic [7:0] exp_q[$];
  // a floating halt pin reads as inactive here
  wire logic [7:0] obs = {power_plane_suspend_n, pci_clock_halt_n | !pci_clock_halt_oe, pci_clock_halt_oe,
    pci_reset_n, processor_reset, processor_sleep_n, processor_clock_halt_request_n, suspend_status_n};
  // short tick keeps the run near ten thousand cycles; waits counted in ticks are unchanged
  localparam int tick_len = 16;
  disk_suspend_resume_sequencer #(
    .tick_last(13'(tick_len - 1))
  ) uut (.*);
  seq_partner #(
    .pgood_delay(1000 * tick_len / seq_pkg::tick_us + 10),
    .grant_delay(4 * tick_len)
  ) far (.*);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic enter(input logic cc);
    exp_q = {exp_q, 8'hf5, 8'hf1, 8'hf0};
    if (cc) exp_q.push_back(8'hb0);
    exp_q = {exp_q, cc ? 8'h30 : 8'h70, 8'h4e};
    repeat ($unsigned($random(seed)) % 200) @(negedge clock);
    suspend_request = 1'b1;
    wait (obs === 8'h4e);
    @(negedge clock);
    suspend_request = 1'b0;
    $display("entry with clock control %0d done", cc);
  endtask
  initial begin
    logic [7:0] last;
    last = 8'hf7;
    forever begin
      @(negedge clock);
      if (mon_on && obs !== last) begin
        if (exp_q.size() == 0) check(obs, last);
        else check(obs, exp_q.pop_front());
        last = obs;
      end
    end
  end
  initial begin
    {rstn, clk_en, suspend_request, resume_event, clock_control_en, slow, mon_on} = 7'h26;
    repeat (3) @(negedge clock);
    rstn = 1'b1;
    mon_on = 1'b1;
    resume_event = 1'b1;
    // random enable gaps: a frozen block must not move either
    repeat (100) begin
      @(negedge clock);
      clk_en = 1'($random(seed));
    end
    @(negedge clock);
    clk_en = 1'b1;
    resume_event = 1'b0;
    $display("resume ignored while on");
    enter(1'b1);
    exp_q = {exp_q, 8'hce, 8'hae, 8'hee, 8'hef, 8'hff, 8'hf7};
    repeat ($unsigned($random(seed)) % 500) @(negedge clock);
    resume_event = 1'b1;
    wait (obs === 8'hff);
    wait (obs === 8'hf7);
    @(negedge clock);
    resume_event = 1'b0;
    check(8'(clocks_running), 8'h01);
    $display("resume done");
    // a new request only once the block is back in the on state
    wait (halt_may_change === 1'b1);
    @(negedge clock);
    clock_control_en = 1'b0;
    slow = 1'b0;
    enter(1'b0);
    check(8'(exp_q.size()), 8'h00);
    exp_q.push_back(8'hf7);
    rstn = 1'b0;
    repeat (3) @(negedge clock);
    rstn = 1'b1;
    repeat (5) @(negedge clock);
    $display("reset from suspend done");
    tally_and_finish();
  end
  // whole run is about 10k cycles, mostly the 500-tick halt hold; limit at 50k cycles
  initial begin
    #200_000;
    mismatches++;
    tally_and_finish();
  end
endmodule
bind disk_suspend_resume_sequencer seq_chk #(.tick_cycles(int'(tick_last) + 1)) chk (.*);
`default_nettype wire
